// *** hdl/fci_host.sv ***
// host controller issuing command sequences to a parallel nor flash
`timescale 1ns/1ns
module fci_host (
  input wire logic clock,
  input wire logic rst,
  input wire logic req_valid,
  input wire fci_pkg::fci_req_t req,
  output logic req_ready,
  output logic done,
  output logic [fci_pkg::DATA_W-1:0] rd_data,
  output logic refused,
  output logic in_suspend,
  output logic in_bypass,
  output logic in_autosel,
  output fci_pkg::fci_pins_t pins,
  input wire logic [fci_pkg::DATA_W-1:0] dq_i,
  input wire logic ready_busy_out
);
  typedef enum logic [2:0] {S_IDLE, S_SETUP, S_PULSE, S_HOLD, S_NEXT} st_t;
  st_t st_r, st_nxt;
  fci_pkg::fci_req_t q_r, q_nxt;
  logic [3:0] step_r, step_nxt, cnt_r, cnt_nxt, nsteps;
  logic susp_r, susp_nxt, byp_r, byp_nxt, asel_r, asel_nxt;
  logic rdy_r, rdy_nxt, done_r, done_nxt, ref_r, ref_nxt;
  logic [fci_pkg::DATA_W-1:0] rdd_r, rdd_nxt;
  fci_pkg::fci_pins_t pins_r, pins_nxt;
  fci_pkg::fci_cyc_t cyc;

  function automatic logic [3:0] steps_of(input fci_pkg::fci_op_t op);
    unique case (op)
      fci_pkg::FCI_OP_SECTOR_ERASE: steps_of = 4'h6;
      fci_pkg::FCI_OP_AUTOSEL_PROT: steps_of = 4'h4;
      fci_pkg::FCI_OP_BYPASS_ENTRY: steps_of = 4'h3;
      fci_pkg::FCI_OP_BYPASS_PROG, fci_pkg::FCI_OP_BYPASS_EXIT:
        steps_of = 4'h2;
      default: steps_of = 4'h1;
    endcase
  endfunction

  // one bus cycle of a sequence; upper data byte zero on commands
  function automatic fci_pkg::fci_cyc_t cyc_of(
      input fci_pkg::fci_req_t r, input logic [3:0] s);
    logic [11:0] a1, a2;
    logic [fci_pkg::ADDR_W-1:0] sa;
    logic [7:0] d;
    logic [fci_pkg::ADDR_W-1:0] a;
    logic rd;
    a1 = r.byte_mode ? fci_pkg::BYTE_ADDR_UNLOCK1 : fci_pkg::WORD_ADDR_UNLOCK1;
    a2 = r.byte_mode ? fci_pkg::BYTE_ADDR_UNLOCK2 : fci_pkg::WORD_ADDR_UNLOCK2;
    sa = '0;
    sa[fci_pkg::SECT_MSB:fci_pkg::SECT_LSB] =
      r.addr[fci_pkg::SECT_MSB:fci_pkg::SECT_LSB];
    a = {7'h00, a1};
    d = fci_pkg::DAT_UNLOCK1;
    rd = 1'b0;
    unique case (r.op)
      fci_pkg::FCI_OP_READ: begin
        a = r.addr;
        rd = 1'b1;
      end
      fci_pkg::FCI_OP_SUSPEND: d = fci_pkg::DAT_SUSPEND;
      fci_pkg::FCI_OP_RESUME: d = fci_pkg::DAT_RESUME;
      fci_pkg::FCI_OP_RESET: d = fci_pkg::DAT_RESET;
      fci_pkg::FCI_OP_SECTOR_ERASE: begin
        unique case (s)
          4'h1, 4'h4: begin
            a = {7'h00, a2};
            d = fci_pkg::DAT_UNLOCK2;
          end
          4'h2: d = fci_pkg::DAT_ERASE_SETUP;
          4'h5: begin
            a = sa;
            d = fci_pkg::DAT_SECTOR_ERASE;
          end
          default: d = fci_pkg::DAT_UNLOCK1;
        endcase
      end
      fci_pkg::FCI_OP_AUTOSEL_PROT: begin
        unique case (s)
          4'h1: begin
            a = {7'h00, a2};
            d = fci_pkg::DAT_UNLOCK2;
          end
          4'h2: d = fci_pkg::DAT_AUTOSEL;
          4'h3: begin
            a = sa | 19'h00002;
            rd = 1'b1;
          end
          default: d = fci_pkg::DAT_UNLOCK1;
        endcase
      end
      fci_pkg::FCI_OP_BYPASS_ENTRY: begin
        if (s == 4'h1) begin
          a = {7'h00, a2};
          d = fci_pkg::DAT_UNLOCK2;
        end else if (s == 4'h2)
          d = fci_pkg::DAT_BYPASS_ENTRY;
      end
      fci_pkg::FCI_OP_BYPASS_PROG: begin
        d = fci_pkg::DAT_BYPASS_PROG;
        if (s == 4'h1) begin
          a = r.addr;
          d = r.data[7:0];
        end
      end
      fci_pkg::FCI_OP_BYPASS_EXIT: begin
        d = (s == 4'h0) ? fci_pkg::DAT_BYPASS_EXIT1
                        : fci_pkg::DAT_BYPASS_EXIT2;
      end
      default: d = fci_pkg::DAT_UNLOCK1;
    endcase
    cyc_of.addr = a;
    cyc_of.data = {8'h00, d};
    if (r.op == fci_pkg::FCI_OP_BYPASS_PROG && s == 4'h1)
      cyc_of.data = r.data;
    cyc_of.rd = rd;
  endfunction

  // request legal in current mode
  function automatic logic legal(input fci_pkg::fci_op_t op, input logic su,
      input logic by, input logic as);
    unique case (op)
      fci_pkg::FCI_OP_RESUME: legal = su && !as;
      fci_pkg::FCI_OP_SUSPEND: legal = !su && !by && !ready_busy_out;
      fci_pkg::FCI_OP_BYPASS_PROG: legal = by;
      fci_pkg::FCI_OP_BYPASS_EXIT: legal = by;
      fci_pkg::FCI_OP_SECTOR_ERASE, fci_pkg::FCI_OP_BYPASS_ENTRY:
        legal = !su && !by && !as && ready_busy_out;
      fci_pkg::FCI_OP_AUTOSEL_PROT: legal = !by && !as;
      fci_pkg::FCI_OP_READ: legal = !by || ready_busy_out;
      default: legal = 1'b1;
    endcase
  endfunction

  assign cyc = cyc_of(q_r, step_r);
  assign nsteps = steps_of(q_r.op);

  always_comb begin
    st_nxt = st_r;
    q_nxt = q_r;
    step_nxt = step_r;
    cnt_nxt = cnt_r;
    susp_nxt = susp_r;
    byp_nxt = byp_r;
    asel_nxt = asel_r;
    rdy_nxt = rdy_r;
    done_nxt = 1'b0;
    ref_nxt = 1'b0;
    rdd_nxt = rdd_r;
    pins_nxt = pins_r;
    unique case (st_r)
      S_IDLE: begin
        if (req_valid && rdy_r) begin
          if (legal(req.op, susp_r, byp_r, asel_r)) begin
            q_nxt = req;
            step_nxt = 4'h0;
            cnt_nxt = 4'h0;
            rdy_nxt = 1'b0;
            st_nxt = S_SETUP;
          end else begin
            ref_nxt = 1'b1;
          end
        end
      end
      S_SETUP: begin
        // address out, chip select low, strobe still high
        pins_nxt.addr = cyc.addr;
        pins_nxt.ce_n = 1'b0;
        pins_nxt.dq_o = cyc.data;
        pins_nxt.dq_oe = !cyc.rd;
        cnt_nxt = cnt_r + 4'h1;
        if (cnt_r + 4'h1 >= fci_pkg::CYC_SETUP) begin
          cnt_nxt = 4'h0;
          pins_nxt.we_n = cyc.rd;
          pins_nxt.oe_n = !cyc.rd;
          st_nxt = S_PULSE;
        end
      end
      S_PULSE: begin
        cnt_nxt = cnt_r + 4'h1;
        if (cnt_r + 4'h1 >= (cyc.rd ? fci_pkg::CYC_READ
                                    : fci_pkg::CYC_PULSE)) begin
          cnt_nxt = 4'h0;
          if (cyc.rd)
            rdd_nxt = dq_i;
          pins_nxt.we_n = 1'b1;
          pins_nxt.oe_n = 1'b1;
          st_nxt = S_HOLD;
        end
      end
      S_HOLD: begin
        cnt_nxt = cnt_r + 4'h1;
        if (cnt_r + 4'h1 >= fci_pkg::CYC_HOLD) begin
          cnt_nxt = 4'h0;
          pins_nxt.ce_n = 1'b1;
          pins_nxt.dq_oe = 1'b0;
          st_nxt = S_NEXT;
        end
      end
      S_NEXT: begin
        if (step_r + 4'h1 < nsteps) begin
          step_nxt = step_r + 4'h1;
          st_nxt = S_SETUP;
        end else begin
          st_nxt = S_IDLE;
          rdy_nxt = 1'b1;
          done_nxt = 1'b1;
          unique case (q_r.op)
            fci_pkg::FCI_OP_SUSPEND: susp_nxt = 1'b1;
            fci_pkg::FCI_OP_RESUME: susp_nxt = 1'b0;
            fci_pkg::FCI_OP_AUTOSEL_PROT: asel_nxt = 1'b1;
            fci_pkg::FCI_OP_RESET: asel_nxt = 1'b0;
            fci_pkg::FCI_OP_BYPASS_ENTRY: byp_nxt = 1'b1;
            fci_pkg::FCI_OP_BYPASS_EXIT: byp_nxt = 1'b0;
            default: begin
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_r <= S_IDLE;
      q_r <= '0;
      step_r <= 4'h0;
      cnt_r <= 4'h0;
      susp_r <= 1'b0;
      byp_r <= 1'b0;
      asel_r <= 1'b0;
      rdy_r <= 1'b1;
      done_r <= 1'b0;
      ref_r <= 1'b0;
      rdd_r <= '0;
      pins_r <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: '0, dq_o: '0,
                  dq_oe: 1'b0};
    end else begin
      st_r <= st_nxt;
      q_r <= q_nxt;
      step_r <= step_nxt;
      cnt_r <= cnt_nxt;
      susp_r <= susp_nxt;
      byp_r <= byp_nxt;
      asel_r <= asel_nxt;
      rdy_r <= rdy_nxt;
      done_r <= done_nxt;
      ref_r <= ref_nxt;
      rdd_r <= rdd_nxt;
      pins_r <= pins_nxt;
    end
  end

  assign req_ready = rdy_r;
  assign done = done_r;
  assign rd_data = rdd_r;
  assign refused = ref_r;
  assign in_suspend = susp_r;
  assign in_bypass = byp_r;
  assign in_autosel = asel_r;
  assign pins = pins_r;

  property p_we_only_with_ce;
    @(posedge clock) disable iff (rst)
      !pins_r.we_n |-> !pins_r.ce_n;
  endproperty
  a_we_only_with_ce: assert property (p_we_only_with_ce)
    else $error("write strobe low without chip select");

  property p_we_oe_excl;
    @(posedge clock) disable iff (rst)
      !(!pins_r.we_n && !pins_r.oe_n);
  endproperty
  a_we_oe_excl: assert property (p_we_oe_excl)
    else $error("write and output strobes both low");

  property p_pulse_len;
    @(posedge clock) disable iff (rst)
      $fell(pins_r.we_n) |-> !pins_r.we_n [*4] ##1 pins_r.we_n;
  endproperty
  a_pulse_len: assert property (p_pulse_len)
    else $error("write pulse length wrong");

  property p_cmd_upper_zero;
    @(posedge clock) disable iff (rst)
      (!pins_r.we_n && q_r.op != fci_pkg::FCI_OP_BYPASS_PROG)
        |-> pins_r.dq_o[15:8] == 8'h00;
  endproperty
  a_cmd_upper_zero: assert property (p_cmd_upper_zero)
    else $error("upper byte driven on command cycle");

  property p_resume_in_susp;
    @(posedge clock) disable iff (rst)
      (st_r == S_IDLE && req_valid && rdy_r
       && req.op == fci_pkg::FCI_OP_RESUME && !susp_r) |=> ref_r;
  endproperty
  a_resume_in_susp: assert property (p_resume_in_susp)
    else $error("resume outside suspend not refused");

  property p_bypass_prog_gate;
    @(posedge clock) disable iff (rst)
      (!pins_r.we_n && pins_r.dq_o[7:0] == fci_pkg::DAT_BYPASS_PROG
       && q_r.op == fci_pkg::FCI_OP_BYPASS_PROG) |-> byp_r;
  endproperty
  a_bypass_prog_gate: assert property (p_bypass_prog_gate)
    else $error("bypass program outside bypass mode");

  property p_suspend_sets;
    @(posedge clock) disable iff (rst)
      (st_r == S_NEXT && q_r.op == fci_pkg::FCI_OP_SUSPEND) |=> susp_r;
  endproperty
  a_suspend_sets: assert property (p_suspend_sets)
    else $error("suspend did not enter suspend mode");

  property p_erase_steps;
    @(posedge clock) disable iff (rst)
      !pins_r.we_n |-> step_r < fci_pkg::MAX_STEPS;
  endproperty
  a_erase_steps: assert property (p_erase_steps)
    else $error("more than six cycles in a sequence");
endmodule

// *** hdl/fci_pkg.sv ***
// package: constants and carriers for the flash command host controller
package fci_pkg;
  localparam int ADDR_W = 19;
  localparam int DATA_W = 16;
  // command sequence addresses and data, word mode and byte mode
  localparam logic [11:0] WORD_ADDR_UNLOCK1 = 12'h555;
  localparam logic [11:0] WORD_ADDR_UNLOCK2 = 12'h2aa;
  localparam logic [11:0] BYTE_ADDR_UNLOCK1 = 12'haaa;
  localparam logic [11:0] BYTE_ADDR_UNLOCK2 = 12'h555;
  localparam logic [7:0] DAT_UNLOCK1 = 8'haa;
  localparam logic [7:0] DAT_UNLOCK2 = 8'h55;
  localparam logic [7:0] DAT_ERASE_SETUP = 8'h80;
  localparam logic [7:0] DAT_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] DAT_SUSPEND = 8'hb0;
  localparam logic [7:0] DAT_RESUME = 8'h30;
  localparam logic [7:0] DAT_AUTOSEL = 8'h90;
  localparam logic [7:0] DAT_RESET = 8'hf0;
  localparam logic [7:0] DAT_BYPASS_ENTRY = 8'h20;
  localparam logic [7:0] DAT_BYPASS_PROG = 8'ha0;
  localparam logic [7:0] DAT_BYPASS_EXIT1 = 8'h90;
  localparam logic [7:0] DAT_BYPASS_EXIT2 = 8'h00;
  localparam logic [7:0] PROT_NO = 8'h00;
  localparam logic [7:0] PROT_YES = 8'h01;
  // sector field in the address
  localparam int SECT_MSB = 18;
  localparam int SECT_LSB = 12;
  localparam int SECT_W = SECT_MSB - SECT_LSB + 1;
  // bus cycle timing
  localparam int CLK_NS = 10;
  localparam int T_SETUP_NS = 20;
  localparam int T_PULSE_NS = 40;
  localparam int T_HOLD_NS = 20;
  localparam int T_READ_NS = 70;
  localparam logic [3:0] CYC_SETUP = 4'((T_SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] CYC_PULSE = 4'((T_PULSE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] CYC_HOLD = 4'((T_HOLD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] CYC_READ = 4'((T_READ_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] MAX_STEPS = 4'h6;

  typedef enum logic [3:0] {
    FCI_OP_READ,
    FCI_OP_SECTOR_ERASE,
    FCI_OP_SUSPEND,
    FCI_OP_RESUME,
    FCI_OP_AUTOSEL_PROT,
    FCI_OP_RESET,
    FCI_OP_BYPASS_ENTRY,
    FCI_OP_BYPASS_PROG,
    FCI_OP_BYPASS_EXIT
  } fci_op_t;

  typedef struct packed {
    fci_op_t op;
    logic byte_mode;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fci_req_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic rd;
  } fci_cyc_t;

  // pins driven toward the flash
  typedef struct packed {
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_o;
    logic dq_oe;
  } fci_pins_t;
endpackage

// *** verification/fci_flash_model.sv ***
// behavioural parallel nor flash answering the host controller
`timescale 1ns/1ns
module fci_flash_model #(
  parameter int ERASE_CYC = 300,
  parameter int PROG_CYC = 20,
  parameter logic [6:0] PROT_SECT = 7'h03
) (
  input wire logic clock,
  input wire fci_pkg::fci_pins_t pins,
  output logic [15:0] dq_i,
  output logic ready_busy_out,
  output int n_wr
);
  logic [15:0] mem [int];
  logic [18:0] a_lat;
  logic [15:0] rd_v = 16'h0000;
  logic [15:0] last_v = 16'h0000;
  logic [2:0] step = 3'h0;
  logic [6:0] es;
  logic susp = 0, asel = 0, byp = 0, bx = 0, pp = 0, erase = 0, tog = 0;
  int busy = 0;
  initial n_wr = 0;

  // embedded algorithm timer, frozen while erase is suspended
  always @(posedge clock) begin
    if (busy > 0 && !susp) begin
      busy = busy - 1;
      if (busy == 0) erase = 0;
    end
  end
  assign ready_busy_out = !(busy > 0 && !susp);

  task automatic wr(input logic [18:0] a, input logic [15:0] dw);
    logic [7:0] d;
    logic u1, u2;
    d = dw[7:0];
    u1 = a[10:0] == 11'h555 || a[11:0] == 12'haaa;
    u2 = a[10:0] == 11'h2aa || a[11:0] == 12'h555;
    n_wr++;
    if (pp) begin
      mem[a] = dw;
      busy = PROG_CYC;
      pp = 0;
    end else if (byp) begin
      pp = d == 8'ha0;
      if (bx && d == 8'h00) byp = 0;
      bx = d == 8'h90;
    end else if (d == 8'hb0 && erase && !susp) susp = 1;
    else if (d == 8'h30 && susp && step == 3'h0) susp = 0;
    else if (d == 8'hf0) begin
      asel = 0;
      step = 3'h0;
    end else begin
      case (step)
        3'h0, 3'h3: step = (u1 && d == 8'haa) ? step + 3'h1 : 3'h0;
        3'h1, 3'h4: step = (u2 && d == 8'h55) ? step + 3'h1 : 3'h0;
        3'h2: begin
          step = (u1 && d == 8'h80) ? 3'h3 : 3'h0;
          asel = u1 && d == 8'h90;
          byp = u1 && d == 8'h20;
        end
        default: begin
          step = 3'h0;
          if (d == 8'h30) begin
            es = a[18:12];
            erase = 1;
            busy = ERASE_CYC;
            foreach (mem[k]) if (k[18:12] == es) mem[k] = 16'hffff;
          end
        end
      endcase
    end
  endtask

  always @(negedge pins.we_n) if (!pins.ce_n) a_lat = pins.addr;
  always @(posedge pins.we_n) if (!pins.ce_n) wr(a_lat, pins.dq_o);

  always @(negedge pins.oe_n) begin
    if (!pins.ce_n) begin
      tog = ~tog;
      if (!ready_busy_out) rd_v = {9'h000, tog, 6'h00};
      else if (asel) rd_v = {15'h0000, pins.addr[18:12] == PROT_SECT};
      else rd_v = mem.exists(pins.addr) ? mem[pins.addr] : 16'hffff;
    end
  end
  // a released bus shows the inverse of the last value read
  always @(posedge pins.oe_n) last_v = rd_v;
  assign dq_i = (!pins.ce_n && !pins.oe_n) ? rd_v : ~last_v;
endmodule

// *** verification/fci_host_bench.sv ***
// self-checking bench for the flash command host controller
`timescale 1ns/1ns
module fci_host_bench;
  logic clock = 0;
  logic rst = 1;
  logic req_valid = 0;
  fci_pkg::fci_req_t req = '0;
  logic req_ready, done, refused, in_suspend, in_bypass, in_autosel;
  logic [15:0] rd_data, dq_i, pd;
  logic ready_busy_out;
  fci_pkg::fci_pins_t pins;
  int n_mismatch = 0, checked = 0, n_cyc = 0, n_wr, wr0;
  logic [31:0] seed = 32'h76a16d15;
  logic [18:0] pa, pe;
  logic [6:0] sec;
  logic bm = 0;

  always #5 clock = ~clock;

  fci_host i_fci_host (.clock(clock), .rst(rst), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .done(done), .rd_data(rd_data),
    .refused(refused), .in_suspend(in_suspend), .in_bypass(in_bypass),
    .in_autosel(in_autosel), .pins(pins), .dq_i(dq_i),
    .ready_busy_out(ready_busy_out));
  fci_flash_model i_fci_flash_model (.clock(clock), .pins(pins),
    .dq_i(dq_i), .ready_busy_out(ready_busy_out), .n_wr(n_wr));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] exp_prot(input logic [6:0] s);
    return (s == 7'h03) ? 32'h1 : 32'h0;
  endfunction

  task automatic chk(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic issue(input fci_pkg::fci_op_t op, input logic [18:0] a,
      input logic [15:0] d, input logic exp_ref);
    int n;
    n = 0;
    @(posedge clock);
    req_valid <= 1'b1;
    req <= '{op: op, byte_mode: bm, addr: a, data: d};
    @(posedge clock);
    req_valid <= 1'b0;
    #1;
    while (done !== 1'b1 && refused !== 1'b1 && n < 500) begin
      @(posedge clock);
      #1;
      n++;
    end
    chk("refused", refused, exp_ref);
    chk("done", done, exp_ref ? 32'h0 : 32'h1);
  endtask

  task automatic wait_rdy();
    int n;
    n = 0;
    while (ready_busy_out !== 1'b1 && n < 1000) begin
      @(posedge clock);
      n++;
    end
    chk("ready", ready_busy_out, 1'h1);
  endtask

  always @(negedge pins.we_n) begin
    chk("ce_n at write", pins.ce_n, 1'h0);
    chk("oe_n at write", pins.oe_n, 1'h1);
    chk("dq_oe at write", pins.dq_oe, 1'h1);
    if (!in_bypass) chk("upper byte", pins.dq_o[15:8], 8'h00);
  end

  // the host must release the data bus for every read cycle
  always @(negedge pins.oe_n) begin
    chk("dq_oe at read", pins.dq_oe, 1'h0);
    chk("we_n at read", pins.we_n, 1'h1);
  end

  always @(posedge clock) begin
    n_cyc++;
    if (n_cyc == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end

  initial begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    #1;
    chk("ce_n", pins.ce_n, 1'h1);
    chk("req_ready", req_ready, 1'h1);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      bm = seed[0];
      sec = (i == 0) ? 7'h03 : seed[7:1];
      pa = {sec ^ 7'h01, seed[19:8]};
      pe = {sec, seed[31:20]};
      pd = seed[23:8];
      issue(fci_pkg::FCI_OP_RESUME, 19'h0, 16'h0, 1'h1);
      issue(fci_pkg::FCI_OP_BYPASS_PROG, pa, pd, 1'h1);
      issue(fci_pkg::FCI_OP_BYPASS_ENTRY, 19'h0, 16'h0, 1'h0);
      chk("in_bypass", in_bypass, 1'h1);
      issue(fci_pkg::FCI_OP_BYPASS_PROG, pa, pd, 1'h0);
      wait_rdy();
      issue(fci_pkg::FCI_OP_BYPASS_PROG, pe, ~pd, 1'h0);
      wait_rdy();
      issue(fci_pkg::FCI_OP_BYPASS_EXIT, 19'h0, 16'h0, 1'h0);
      chk("in_bypass", in_bypass, 1'h0);
      issue(fci_pkg::FCI_OP_READ, pa, 16'h0, 1'h0);
      chk("read", rd_data, pd);
      wr0 = n_wr;
      issue(fci_pkg::FCI_OP_SECTOR_ERASE, {sec, 12'h000}, 16'h0, 1'h0);
      chk("erase writes", n_wr - wr0, 32'h6);
      chk("busy", ready_busy_out, 1'h0);
      issue(fci_pkg::FCI_OP_SUSPEND, pe, 16'h0, 1'h0);
      chk("in_suspend", in_suspend, 1'h1);
      chk("ready", ready_busy_out, 1'h1);
      issue(fci_pkg::FCI_OP_READ, pa, 16'h0, 1'h0);
      chk("read", rd_data, pd);
      issue(fci_pkg::FCI_OP_AUTOSEL_PROT, {sec, 12'h000}, 16'h0, 1'h0);
      chk("protect", rd_data, exp_prot(sec));
      chk("in_autosel", in_autosel, 1'h1);
      issue(fci_pkg::FCI_OP_RESUME, 19'h0, 16'h0, 1'h1);
      issue(fci_pkg::FCI_OP_RESET, 19'h0, 16'h0, 1'h0);
      chk("in_autosel", in_autosel, 1'h0);
      issue(fci_pkg::FCI_OP_RESUME, pa, 16'h0, 1'h0);
      chk("in_suspend", in_suspend, 1'h0);
      chk("busy", ready_busy_out, 1'h0);
      wait_rdy();
      issue(fci_pkg::FCI_OP_READ, pe, 16'h0, 1'h0);
      chk("erased", rd_data, 16'hffff);
      issue(fci_pkg::FCI_OP_READ, pa, 16'h0, 1'h0);
      chk("kept", rd_data, pd);
      issue(fci_pkg::FCI_OP_SUSPEND, 19'h0, 16'h0, 1'h1);
    end
    // reset in mid-run clears the mode the host tracks
    issue(fci_pkg::FCI_OP_BYPASS_ENTRY, 19'h0, 16'h0, 1'h0);
    chk("in_bypass", in_bypass, 1'h1);
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    #1;
    chk("in_bypass", in_bypass, 1'h0);
    chk("req_ready", req_ready, 1'h1);
    chk("ce_n", pins.ce_n, 1'h1);
    stop_test();
  end
endmodule
